// >>> rtl/comparator_pkg.sv
// package: register map, field positions and types for the comparator control block
// Notes on behaviour
// (R1) The raw comparator result is high when the selected positive input exceeds the negative.
// (R2) Software sees the result only after a two-stage synchroniser, one to two cycles late.
// (R3) Event mode 00 is any toggle, 01 reserved, 10 falling edge, 11 rising edge.
// (R4) The event flag (control/status bit 4) sets whenever the chosen event is seen.
// (R5) The interrupt request is high only while flag, irq enable and global enable are all one.
// (R6) The flag clears when the processor takes the comparator interrupt vector.
// (R7) Writing one to the flag bit clears it; writing zero leaves it.
// (R8) The power-off bit (bit 7) switches the comparator off at any time; clearing it restores it.
// (R9) Software clears the irq enable before changing the power-off bit.
// (R10) Software clears the irq enable before rewriting the event mode field.
// (R11) Reference select (bit 6) routes the internal reference to the positive input, else the pin.
// (R12) With mux enable one and converter off, channel select picks channel 0..3 as negative input.
// (R13) Bit 2 of the control/status register is reserved and reads zero.
// (R14) A pin's buffer-off bit disables its input buffer and forces its port bit to read zero.
// (R15) Software should set buffer-off bits on analog pins whose digital value is unused.
// (R16) In converter control B only bit 6 and bits 2..0 are writable; all reset to zero.
// (R17) Edges are found by comparing the synchronised result with its value one cycle earlier.
package comparator_pkg;
   // register addresses on the plain register port
   localparam logic [1:0] ADDR_CONV_CTRL_B = 2'h0;
   localparam logic [1:0] ADDR_CMP_CTRL    = 2'h1;
   localparam logic [1:0] ADDR_DIG_DISABLE = 2'h2;
   // control/status field positions
   localparam int CS_POWER_OFF = 7;
   localparam int CS_REF_SEL   = 6;
   localparam int CS_RESULT    = 5;
   localparam int CS_FLAG      = 4;
   localparam int CS_IRQ_EN    = 3;
   // converter control B field positions and writable mask
   localparam int CB_MUX_EN = 6;
   localparam logic [7:0] CB_WRITE_MASK = 8'h47;
   // digital input disable: writable mask and pin bit positions
   localparam logic [7:0] DD_WRITE_MASK = 8'h3F;
   localparam int DD_NEG_PIN = 1;
   localparam int DD_POS_PIN = 0;
   // reset values
   localparam logic [7:0] CONV_CTRL_B_RESET = 8'h00;
   localparam logic [7:0] DIG_DISABLE_RESET = 8'h00;
   localparam logic [7:0] CMP_CTRL_RESET    = 8'h00;
   // event modes
   typedef enum logic [1:0] {
      MODE_TOGGLE   = 2'b00,
      MODE_RESERVED = 2'b01,
      MODE_FALLING  = 2'b10,
      MODE_RISING   = 2'b11
   } event_mode_t;
   // analog input selection travelling together
   typedef struct packed {
      logic       pos_is_reference;
      logic       neg_is_channel;
      logic [1:0] neg_channel;
   } input_select_t;
endpackage

// >>> rtl/comparator_control.sv
// comparator control: input routing, synchroniser, edge events, flag and registers
//
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/1ns
module comparator_control (
   // clock and reset
   input  wire logic                       CLOCK,
   input  wire logic                       RSTN,
   // register port
   input  wire logic [1:0]                 ADDR,
   input  wire logic [7:0]                 WDATA,
   input  wire logic                       WR,
   input  wire logic                       RD,
   output logic      [7:0]                 RDATA,
   // analog comparator side
   input  wire logic                       VPOS_PIN_GT_NEG,
   input  wire logic                       VREF_GT_NEG,
   input  wire logic [3:0]                 VPOS_GT_CHANNEL,
   input  wire logic                       VREF_GT_CHANNEL_ANY,
   output comparator_pkg::input_select_t   INPUT_SELECT,
   output logic                            COMPARATOR_POWER_OFF,
   // digital pins and converter
   input  wire logic                       POS_PIN_IN,
   input  wire logic                       NEG_PIN_IN,
   output logic                            POS_PORT_BIT,
   output logic                            NEG_PORT_BIT,
   output logic      [5:0]                 BUFFER_OFF,
   input  wire logic                       CONVERTER_ENABLE,
   output logic      [2:0]                 TRIGGER_SELECT,
   // processor interrupt
   input  wire logic                       GLOBAL_IRQ_ENABLE,
   input  wire logic                       VECTOR_TAKEN,
   output logic                            IRQ
);
   logic       rst_meta_reg, rst_n_reg;
   logic [7:0] conv_b_reg, dig_dis_reg;
   logic       power_off_reg, ref_sel_reg, flag_reg, irq_en_reg;
   logic [1:0] mode_reg;
   logic [1:0] chan_sel_reg;
   logic       raw_result, sync1_reg, sync2_reg, prev_reg;
   logic       rise, fall, event_hit;
   comparator_pkg::input_select_t sel;

   // reset release through two flip-flops
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         rst_meta_reg <= 1'b0;
         rst_n_reg    <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n_reg    <= rst_meta_reg;
      end
   end

   // input routing
   always_comb begin
      sel.pos_is_reference = ref_sel_reg;                                  // R11
      sel.neg_is_channel   = conv_b_reg[comparator_pkg::CB_MUX_EN] & ~CONVERTER_ENABLE; // R12
      sel.neg_channel      = chan_sel_reg;                                 // R12
   end
   assign INPUT_SELECT = sel;

   // raw decision from the selected pair; forced low while powered off
   always_comb begin
      if (power_off_reg) begin
         raw_result = 1'b0;                                                // R8
      end else if (sel.neg_is_channel) begin
         raw_result = sel.pos_is_reference ? VREF_GT_CHANNEL_ANY
                                           : VPOS_GT_CHANNEL[sel.neg_channel]; // R1
      end else begin
         raw_result = sel.pos_is_reference ? VREF_GT_NEG : VPOS_PIN_GT_NEG; // R1
      end
   end

   // synchroniser and one-cycle history
   always_ff @(posedge CLOCK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         prev_reg  <= 1'b0;
      end else begin
         sync1_reg <= raw_result;                                          // R2
         sync2_reg <= sync1_reg;                                           // R2
         prev_reg  <= sync2_reg;                                           // R17
      end
   end

   // edge pulses and event selection
   assign rise = sync2_reg & ~prev_reg;                                    // R17
   assign fall = ~sync2_reg & prev_reg;                                    // R17
   always_comb begin
      case (comparator_pkg::event_mode_t'(mode_reg))                       // R3
         comparator_pkg::MODE_TOGGLE:  event_hit = rise | fall;
         comparator_pkg::MODE_FALLING: event_hit = fall;
         comparator_pkg::MODE_RISING:  event_hit = rise;
         default:                      event_hit = 1'b0;
      endcase
   end

   // event flag: set wins over clear
   always_ff @(posedge CLOCK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         flag_reg <= 1'b0;
      end else if (event_hit) begin
         flag_reg <= 1'b1;                                                 // R4
      end else if (VECTOR_TAKEN) begin
         flag_reg <= 1'b0;                                                 // R6
      end else if (WR && ADDR == comparator_pkg::ADDR_CMP_CTRL
                   && WDATA[comparator_pkg::CS_FLAG]) begin
         flag_reg <= 1'b0;                                                 // R7
      end
   end

   // control/status writable fields
   always_ff @(posedge CLOCK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         power_off_reg <= comparator_pkg::CMP_CTRL_RESET[comparator_pkg::CS_POWER_OFF];
         ref_sel_reg   <= comparator_pkg::CMP_CTRL_RESET[comparator_pkg::CS_REF_SEL];
         irq_en_reg    <= comparator_pkg::CMP_CTRL_RESET[comparator_pkg::CS_IRQ_EN];
         mode_reg      <= comparator_pkg::CMP_CTRL_RESET[1:0];
      end else if (WR && ADDR == comparator_pkg::ADDR_CMP_CTRL) begin
         power_off_reg <= WDATA[comparator_pkg::CS_POWER_OFF];             // R8
         ref_sel_reg   <= WDATA[comparator_pkg::CS_REF_SEL];
         irq_en_reg    <= WDATA[comparator_pkg::CS_IRQ_EN];
         mode_reg      <= WDATA[1:0];
      end
   end

   // converter control B and digital input disable
   always_ff @(posedge CLOCK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         conv_b_reg   <= comparator_pkg::CONV_CTRL_B_RESET;
         dig_dis_reg  <= comparator_pkg::DIG_DISABLE_RESET;
         chan_sel_reg <= 2'b00;
      end else if (WR) begin
         if (ADDR == comparator_pkg::ADDR_CONV_CTRL_B) begin
            conv_b_reg <= WDATA & comparator_pkg::CB_WRITE_MASK;           // R16
         end
         if (ADDR == comparator_pkg::ADDR_DIG_DISABLE) begin
            dig_dis_reg <= WDATA & comparator_pkg::DD_WRITE_MASK;
         end
         if (ADDR == 2'h3) begin
            chan_sel_reg <= WDATA[1:0];                                    // channel select
         end
      end
   end

   // read data, one cycle after the strobe
   always_ff @(posedge CLOCK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         RDATA <= 8'h00;
      end else if (RD) begin
         case (ADDR)
            comparator_pkg::ADDR_CONV_CTRL_B: RDATA <= conv_b_reg;
            comparator_pkg::ADDR_CMP_CTRL:
               RDATA <= {power_off_reg, ref_sel_reg, sync2_reg, flag_reg,
                         irq_en_reg, 1'b0, mode_reg};                      // R13
            comparator_pkg::ADDR_DIG_DISABLE: RDATA <= dig_dis_reg;
            default:                          RDATA <= {6'h00, chan_sel_reg};
         endcase
      end else begin
         RDATA <= 8'h00;
      end
   end

   // pins, buffers, power and interrupt
   assign POS_PORT_BIT = POS_PIN_IN & ~dig_dis_reg[comparator_pkg::DD_POS_PIN]; // R14
   assign NEG_PORT_BIT = NEG_PIN_IN & ~dig_dis_reg[comparator_pkg::DD_NEG_PIN]; // R14
   assign BUFFER_OFF   = dig_dis_reg[5:0];                                 // R14
   assign COMPARATOR_POWER_OFF = power_off_reg;                            // R8
   assign TRIGGER_SELECT = conv_b_reg[2:0];
   assign IRQ = flag_reg & irq_en_reg & GLOBAL_IRQ_ENABLE;                 // R5
endmodule

// >>> bench/comparator_control_sva.sv
// port assertions for the comparator control block
`timescale 1ns/1ns
module comparator_control_sva (
   // clock, reset and register port
   input wire logic                          CLOCK, RSTN, WR, RD,
   input wire logic [1:0]                    ADDR,
   input wire logic [7:0]                    WDATA, RDATA,
   // analog routing and pins
   input wire comparator_pkg::input_select_t INPUT_SELECT,
   input wire logic                          COMPARATOR_POWER_OFF, CONVERTER_ENABLE,
   input wire logic                          POS_PIN_IN, NEG_PIN_IN, POS_PORT_BIT, NEG_PORT_BIT,
   input wire logic [5:0]                    BUFFER_OFF,
   input wire logic [2:0]                    TRIGGER_SELECT,
   // interrupt
   input wire logic                          GLOBAL_IRQ_ENABLE, VECTOR_TAKEN, IRQ
);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RSTN);
   AST_POS_PORT: assert property (POS_PORT_BIT == (POS_PIN_IN && !BUFFER_OFF[0]))
      else $error("positive port bit not gated by its buffer-off bit");
   AST_NEG_PORT: assert property (BUFFER_OFF[1] |-> !NEG_PORT_BIT)
      else $error("negative port bit reads one while buffer is off");
   AST_IRQ_GATE: assert property (IRQ |-> GLOBAL_IRQ_ENABLE)
      else $error("interrupt request without global enable");
   AST_CHANNEL_NEG: assert property (INPUT_SELECT.neg_is_channel |-> !CONVERTER_ENABLE)
      else $error("channel routed to negative input while converter on");
   AST_RESERVED_BIT: assert property (RD && ADDR == 2'h1 |=> RDATA[2] == 1'b0)
      else $error("reserved status bit reads one");
   AST_CONVB_RO: assert property (RD && ADDR == 2'h0 |=> (RDATA & 8'hB8) == 8'h00)
      else $error("read-only converter bits read nonzero");
   AST_POWER_WRITE: assert property (WR && ADDR == 2'h1 |=> COMPARATOR_POWER_OFF == $past(WDATA[7]))
      else $error("power-off output does not follow write");
   AST_POWER_HOLD: assert property (!(WR && ADDR == 2'h1) |=> $stable(COMPARATOR_POWER_OFF))
      else $error("power-off output changed without a write");
   AST_REF_WRITE: assert property (WR && ADDR == 2'h1 |=>
      INPUT_SELECT.pos_is_reference == $past(WDATA[6]))
      else $error("reference select does not follow write");
   AST_TRIGGER_WRITE: assert property (WR && ADDR == 2'h0 |=> TRIGGER_SELECT == $past(WDATA[2:0]))
      else $error("trigger select does not follow write");
   // main scenarios reached
   cover property ($rose(IRQ));
   cover property (VECTOR_TAKEN && IRQ);
   cover property (RD && ADDR == 2'h1);
endmodule
bind comparator_control comparator_control_sva chk (.CLOCK(CLOCK), .RSTN(RSTN), .WR(WR), .RD(RD),
   .ADDR(ADDR), .WDATA(WDATA), .RDATA(RDATA), .INPUT_SELECT(INPUT_SELECT),
   .COMPARATOR_POWER_OFF(COMPARATOR_POWER_OFF), .CONVERTER_ENABLE(CONVERTER_ENABLE),
   .POS_PIN_IN(POS_PIN_IN), .NEG_PIN_IN(NEG_PIN_IN), .POS_PORT_BIT(POS_PORT_BIT),
   .NEG_PORT_BIT(NEG_PORT_BIT), .BUFFER_OFF(BUFFER_OFF), .TRIGGER_SELECT(TRIGGER_SELECT),
   .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE), .VECTOR_TAKEN(VECTOR_TAKEN), .IRQ(IRQ));

// >>> bench/comparator_control_tb.sv
// self-checking bench for the comparator control block
`timescale 1ns/1ns
module comparator_control_tb;
   logic                          CLOCK, RSTN, WR, RD, VPOS_PIN_GT_NEG, VREF_GT_NEG, VREF_GT_CHANNEL_ANY;
   logic                          POS_PIN_IN, NEG_PIN_IN, CONVERTER_ENABLE, GLOBAL_IRQ_ENABLE, VECTOR_TAKEN;
   logic                          COMPARATOR_POWER_OFF, POS_PORT_BIT, NEG_PORT_BIT, IRQ;
   logic [1:0]                    ADDR;
   logic [7:0]                    WDATA, RDATA;
   logic [3:0]                    VPOS_GT_CHANNEL;
   logic [5:0]                    BUFFER_OFF;
   logic [2:0]                    TRIGGER_SELECT;
   comparator_pkg::input_select_t INPUT_SELECT;
   int                            miscompares = 0;
   int                            samples_checked = 0;
   comparator_control dut (.CLOCK(CLOCK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
      .RDATA(RDATA), .VPOS_PIN_GT_NEG(VPOS_PIN_GT_NEG), .VREF_GT_NEG(VREF_GT_NEG),
      .VPOS_GT_CHANNEL(VPOS_GT_CHANNEL), .VREF_GT_CHANNEL_ANY(VREF_GT_CHANNEL_ANY),
      .INPUT_SELECT(INPUT_SELECT), .COMPARATOR_POWER_OFF(COMPARATOR_POWER_OFF),
      .POS_PIN_IN(POS_PIN_IN), .NEG_PIN_IN(NEG_PIN_IN), .POS_PORT_BIT(POS_PORT_BIT),
      .NEG_PORT_BIT(NEG_PORT_BIT), .BUFFER_OFF(BUFFER_OFF), .CONVERTER_ENABLE(CONVERTER_ENABLE),
      .TRIGGER_SELECT(TRIGGER_SELECT), .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE),
      .VECTOR_TAKEN(VECTOR_TAKEN), .IRQ(IRQ));
   // 50 MHz system clock
   initial begin
      CLOCK = 1'b0;
      forever #10 CLOCK = ~CLOCK;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one-cycle write strobe, then one idle edge so back-to-back calls never reassign WR
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      ADDR <= a; WDATA <= d; WR <= 1'b1;
      @(posedge CLOCK);
      WR <= 1'b0;
      @(posedge CLOCK);
   endtask
   // read strobe, data checked in the following cycle only
   task automatic rd(input logic [1:0] a, input logic [7:0] exp);
      ADDR <= a; RD <= 1'b1;
      @(posedge CLOCK);
      RD <= 1'b0;
      #1 chk(RDATA, exp);
      @(posedge CLOCK);
   endtask
   // clear flag, set mode, move the input, then read status
   task automatic edge_chk(input logic [1:0] m, input logic lv, input logic ev);
      wr(2'h1, {3'h0, 1'b1, 2'h0, m});
      VPOS_PIN_GT_NEG <= lv;
      repeat (4) @(posedge CLOCK);
      rd(2'h1, {2'h0, lv, ev, 2'h0, m});
   endtask
   task automatic summarize;
      $display("checks=%0d mismatches=%0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      RSTN = 1'b0; WR = 1'b0; RD = 1'b0; ADDR = 2'h0; WDATA = 8'h00; VPOS_PIN_GT_NEG = 1'b0;
      VREF_GT_NEG = 1'b0; VREF_GT_CHANNEL_ANY = 1'b0; VPOS_GT_CHANNEL = 4'h0; POS_PIN_IN = 1'b1;
      NEG_PIN_IN = 1'b1; CONVERTER_ENABLE = 1'b0; GLOBAL_IRQ_ENABLE = 1'b0; VECTOR_TAKEN = 1'b0;
      repeat (4) @(posedge CLOCK);
      RSTN <= 1'b1;
      repeat (3) @(posedge CLOCK);
      rd(2'h0, 8'h00);
      rd(2'h1, 8'h00);
      rd(2'h2, 8'h00);
      chk({6'h00, POS_PORT_BIT, NEG_PORT_BIT}, 8'h03);
      wr(2'h0, 8'hFF);
      wr(2'h2, 8'hFF);
      rd(2'h0, 8'h47);
      rd(2'h2, 8'h3F);
      chk({5'h00, TRIGGER_SELECT}, 8'h07);
      chk({BUFFER_OFF, POS_PORT_BIT, NEG_PORT_BIT}, 8'hFC);
      wr(2'h0, 8'h00);
      for (int m = 0; m < 4; m++) begin
         edge_chk(m[1:0], 1'b1, 4'b1001 >> m);
         edge_chk(m[1:0], 1'b0, 4'b0101 >> m);
      end
      wr(2'h1, 8'h00);
      VPOS_PIN_GT_NEG <= 1'b1;
      rd(2'h1, 8'h00);
      repeat (3) @(posedge CLOCK);
      wr(2'h1, 8'h00);
      rd(2'h1, 8'h30);
      wr(2'h1, 8'h1B);
      GLOBAL_IRQ_ENABLE <= 1'b1;
      VPOS_PIN_GT_NEG <= 1'b0;
      repeat (4) @(posedge CLOCK);
      #1 chk({7'h00, IRQ}, 8'h00);
      @(posedge CLOCK);
      VPOS_PIN_GT_NEG <= 1'b1;
      repeat (4) @(posedge CLOCK);
      #1 chk({7'h00, IRQ}, 8'h01);
      @(posedge CLOCK);
      GLOBAL_IRQ_ENABLE <= 1'b0;
      #1 chk({7'h00, IRQ}, 8'h00);
      @(posedge CLOCK);
      GLOBAL_IRQ_ENABLE <= 1'b1;
      VECTOR_TAKEN <= 1'b1;
      @(posedge CLOCK);
      VECTOR_TAKEN <= 1'b0;
      #1 chk({7'h00, IRQ}, 8'h00);
      @(posedge CLOCK);
      rd(2'h1, 8'h2B);
      wr(2'h1, 8'h10);
      wr(2'h1, 8'h90);
      repeat (4) @(posedge CLOCK);
      chk({7'h00, COMPARATOR_POWER_OFF}, 8'h01);
      rd(2'h1, 8'h90);
      wr(2'h1, 8'h10);
      wr(2'h1, 8'h50);
      repeat (4) @(posedge CLOCK);
      rd(2'h1, 8'h50);
      VREF_GT_NEG <= 1'b1;
      repeat (4) @(posedge CLOCK);
      rd(2'h1, 8'h70);
      VPOS_GT_CHANNEL <= 4'h4;
      wr(2'h3, 8'h02);
      rd(2'h3, 8'h02);
      wr(2'h1, 8'h10);
      wr(2'h0, 8'h40);
      VPOS_PIN_GT_NEG <= 1'b0;
      repeat (4) @(posedge CLOCK);
      chk({4'h0, INPUT_SELECT}, 8'h06);
      rd(2'h1, 8'h20);
      CONVERTER_ENABLE <= 1'b1;
      repeat (4) @(posedge CLOCK);
      chk({7'h00, INPUT_SELECT.neg_is_channel}, 8'h00);
      rd(2'h1, 8'h10);
      summarize();
   end
endmodule
